// ==== ptc_defines.svh ====
// Constants for the pointer control and general word register block
// Behaviour
// - Select resets 00, pointer 0 not yet active
// - Writes of selected pointer or control activate
// - Auto increment/decrement changes neither select nor activation
// - Write-through data write selects its own pointer
// - Control bit 2: pointer 0 word mode
// - Control bit 3: pointer 1 word mode
// - Control bit 4: frame pointer word mode
// - Control bits 15..5 read zero
// - General word clears on reset, free access
// - Byte reads and writes via byte locations
// - Swap location returns bytes exchanged
// - Low byte view reads 00h after reset
// - Low byte write stores bits 7:0
// - Low byte read returns least significant byte
// - Select 00/01/10 decode; 11 means frame
// - High byte location writes/reads upper byte
// - Swap location is read-only
`ifndef PTC_DEFINES_SVH
`define PTC_DEFINES_SVH
`define PTC_IDX_CTL 4
`define PTC_IDX_WORD 5
`define PTC_IDX_LOW 6
`define PTC_IDX_SWAP 8
`define PTC_IDX_HIGH 9
`define PTC_CTL_W 5
`define PTC_CTL_RST 5'h1C
`define PTC_SEL_LSB 0
`define PTC_SEL_MSB 1
`define PTC_WM0_BIT 2
`define PTC_WM1_BIT 3
`define PTC_WMF_BIT 4
`define PTC_WORD_RST 16'h0000
`endif

// ==== ptc_pkg.sv ====
// Types for the pointer control and general word register block
package ptc_pkg;
	typedef enum logic [1:0] {
		PTC_PTR_DP0 = 2'h0,
		PTC_PTR_DP1 = 2'h1,
		PTC_PTR_FRAME = 2'h2
	} ptc_ptr_t;
endpackage

// ==== ptc_swap.sv ====
// Byte exchange of a 16-bit word
`timescale 1ns/10ps
module ptc_swap #(
	parameter int BYTE_W = 8
) (
	// Word in
	input wire logic [2*BYTE_W-1:0] word_in,
	// Swapped word out
	output logic [2*BYTE_W-1:0] word_out
);
	always_comb begin
		word_out = {word_in[BYTE_W-1:0], word_in[2*BYTE_W-1:BYTE_W]};
	end
endmodule

// ==== ptc_top.sv ====
// Pointer control register and general word register behind an APB slave
`timescale 1ns/10ps
`include "ptc_defines.svh"
module ptc_top #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core pointer events
	input wire logic core_wr_dp0,
	input wire logic core_wr_dp1,
	input wire logic core_wr_base,
	input wire logic core_wr_offs,
	input wire logic core_mem_wr,
	input wire ptc_pkg::ptc_ptr_t core_mem_wr_ptr,
	input wire logic write_through_en,
	// Pointer control state
	output logic [1:0] source_pointer_select,
	output logic src_ptr_active,
	output ptc_pkg::ptc_ptr_t active_ptr,
	output logic active_word_mode,
	output logic ptr0_word_mode,
	output logic ptr1_word_mode,
	output logic frame_ptr_word_mode,
	// General word
	output logic [15:0] general_word
);
	localparam int IW = ADDR_W - 2;
	localparam logic [IW-1:0] IDX_CTL = IW'(`PTC_IDX_CTL);
	localparam logic [IW-1:0] IDX_WORD = IW'(`PTC_IDX_WORD);
	localparam logic [IW-1:0] IDX_LOW = IW'(`PTC_IDX_LOW);
	localparam logic [IW-1:0] IDX_SWAP = IW'(`PTC_IDX_SWAP);
	localparam logic [IW-1:0] IDX_HIGH = IW'(`PTC_IDX_HIGH);

	// Reserved code 11 falls back to the frame pointer
	function automatic ptc_pkg::ptc_ptr_t ptc_decode(input logic [1:0] sel);
		ptc_pkg::ptc_ptr_t p;
		case (sel)
			2'h0: p = ptc_pkg::PTC_PTR_DP0;
			2'h1: p = ptc_pkg::PTC_PTR_DP1;
			default: p = ptc_pkg::PTC_PTR_FRAME;
		endcase
		return p;
	endfunction

	function automatic logic ptc_wmode(input logic [`PTC_CTL_W-1:0] ctl,
		input ptc_pkg::ptc_ptr_t p);
		logic m;
		case (p)
			ptc_pkg::PTC_PTR_DP0: m = ctl[`PTC_WM0_BIT];
			ptc_pkg::PTC_PTR_DP1: m = ctl[`PTC_WM1_BIT];
			default: m = ctl[`PTC_WMF_BIT];
		endcase
		return m;
	endfunction

	logic [`PTC_CTL_W-1:0] ctl_ff, nxt_ctl;
	logic active_ff, nxt_active;
	ptc_pkg::ptc_ptr_t act_ptr_ff, nxt_act_ptr;
	logic act_wm_ff, nxt_act_wm;
	logic [15:0] word_ff, nxt_word;
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr;
	logic [IW-1:0] idx;
	logic access;
	logic wr_go;
	logic sel_hit;
	logic wt_hit;
	logic ctl_wr;
	logic [15:0] word_swapped;
	ptc_pkg::ptc_ptr_t sel_ptr;

	ptc_swap #(
		.BYTE_W(8)
	) u_swap (
		.word_in(word_ff),
		.word_out(word_swapped)
	);

	always_comb begin
		idx = paddr[ADDR_W-1:2];
		access = psel & penable;
		wr_go = access & pready_ff & pwrite;
		ctl_wr = wr_go && (idx == IDX_CTL);
		sel_ptr = ptc_decode(ctl_ff[`PTC_SEL_MSB:`PTC_SEL_LSB]);
		// Only a write of the pointer now selected activates it
		sel_hit = ((sel_ptr == ptc_pkg::PTC_PTR_DP0) && core_wr_dp0) ||
			((sel_ptr == ptc_pkg::PTC_PTR_DP1) && core_wr_dp1) ||
			((sel_ptr == ptc_pkg::PTC_PTR_FRAME) && (core_wr_base || core_wr_offs));
		wt_hit = core_mem_wr & write_through_en;
	end

	// Pointer control and general word
	always_comb begin
		nxt_ctl = ctl_ff;
		nxt_active = active_ff;
		nxt_word = word_ff;
		// Increment/decrement has no input here: it cannot disturb select
		if (sel_hit) begin
			nxt_active = 1'b1;
		end
		if (wt_hit) begin
			nxt_ctl[`PTC_SEL_MSB:`PTC_SEL_LSB] = 2'(core_mem_wr_ptr);
			nxt_active = 1'b1;
		end
		// A software write in the same cycle is the later instruction and wins
		if (wr_go) begin
			case (idx)
				IDX_CTL: begin
					nxt_ctl = pwdata[`PTC_CTL_W-1:0];
					nxt_active = 1'b1;
				end
				IDX_WORD: begin
					nxt_word = pwdata[15:0];
				end
				IDX_LOW: begin
					nxt_word = {word_ff[15:8], pwdata[7:0]};
				end
				IDX_HIGH: begin
					nxt_word = {pwdata[7:0], word_ff[7:0]};
				end
				default: begin
					nxt_word = word_ff;
				end
			endcase
		end
		nxt_act_ptr = ptc_decode(nxt_ctl[`PTC_SEL_MSB:`PTC_SEL_LSB]);
		nxt_act_wm = ptc_wmode(nxt_ctl, nxt_act_ptr);
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ctl_ff <= `PTC_CTL_RST;
			active_ff <= 1'b0;
			act_ptr_ff <= ptc_pkg::PTC_PTR_DP0;
			act_wm_ff <= 1'b1;
			word_ff <= `PTC_WORD_RST;
		end else begin
			ctl_ff <= nxt_ctl;
			active_ff <= nxt_active;
			act_ptr_ff <= nxt_act_ptr;
			act_wm_ff <= nxt_act_wm;
			word_ff <= nxt_word;
		end
	end

	// APB answer: one wait state, read data captured before pready
	always_comb begin
		nxt_pready = access & ~pready_ff;
		nxt_prdata = prdata_ff;
		nxt_pslverr = 1'b0;
		if (access && !pready_ff) begin
			nxt_prdata = 32'h0;
			case (idx)
				IDX_CTL: begin
					nxt_prdata[`PTC_CTL_W-1:0] = ctl_ff;
				end
				IDX_WORD: begin
					nxt_prdata[15:0] = word_ff;
				end
				IDX_LOW: begin
					nxt_prdata[7:0] = word_ff[7:0];
				end
				IDX_HIGH: begin
					nxt_prdata[7:0] = word_ff[15:8];
				end
				IDX_SWAP: begin
					nxt_prdata[15:0] = word_swapped;
					nxt_pslverr = pwrite;
				end
				default: begin
					nxt_pslverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			prdata_ff <= 32'h0;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign source_pointer_select = ctl_ff[`PTC_SEL_MSB:`PTC_SEL_LSB];
	assign src_ptr_active = active_ff;
	assign active_ptr = act_ptr_ff;
	assign active_word_mode = act_wm_ff;
	assign ptr0_word_mode = ctl_ff[`PTC_WM0_BIT];
	assign ptr1_word_mode = ctl_ff[`PTC_WM1_BIT];
	assign frame_ptr_word_mode = ctl_ff[`PTC_WMF_BIT];
	assign general_word = word_ff;

	logic rd_done;
	assign rd_done = access & pready_ff & ~pwrite;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	AST_RESET_STATE: assert property (disable iff (1'b0)
		!resetn |=> (source_pointer_select == 2'h0) && !src_ptr_active &&
		(general_word == 16'h0000))
		else $error("Reset state of select, activation or word wrong");
	AST_ACTIVE_CAUSE: assert property (
		$rose(src_ptr_active) |-> $past(ctl_wr || sel_hit || wt_hit))
		else $error("Source pointer activated without a cause");
	AST_SELECT_HOLD: assert property (
		!ctl_wr && !wt_hit |=> $stable(source_pointer_select))
		else $error("Select changed with no control or write-through write");
	AST_WRITE_THROUGH: assert property (
		wt_hit && !ctl_wr |=> (source_pointer_select == $past(2'(core_mem_wr_ptr)))
		&& src_ptr_active)
		else $error("Write-through did not select the writing pointer");
	AST_NO_WT: assert property (
		core_mem_wr && !write_through_en && !ctl_wr |=> $stable(source_pointer_select))
		else $error("Memory write moved select without write-through");
	AST_WORD_MODES: assert property (
		ctl_wr |=> (ptr0_word_mode == $past(pwdata[`PTC_WM0_BIT])) &&
		(ptr1_word_mode == $past(pwdata[`PTC_WM1_BIT])) &&
		(frame_ptr_word_mode == $past(pwdata[`PTC_WMF_BIT])))
		else $error("Word mode bits not taken from control write");
	AST_ACTIVE_WMODE: assert property (
		((active_ptr == ptc_pkg::PTC_PTR_DP0) && (active_word_mode == ptr0_word_mode)) ||
		((active_ptr == ptc_pkg::PTC_PTR_DP1) && (active_word_mode == ptr1_word_mode)) ||
		((active_ptr == ptc_pkg::PTC_PTR_FRAME) && (active_word_mode == frame_ptr_word_mode)))
		else $error("Active word mode not that of the active pointer");
	AST_RESET_MODES: assert property (disable iff (1'b0)
		!resetn |=> ptr0_word_mode && ptr1_word_mode && frame_ptr_word_mode)
		else $error("Word modes not set by reset");
	AST_WRITE_ACT: assert property (
		ctl_wr |=> src_ptr_active)
		else $error("Control write did not activate the source pointer");
	AST_DP0_IMPLICIT: assert property (
		core_wr_dp0 && (sel_ptr == ptc_pkg::PTC_PTR_DP0) |=> src_ptr_active)
		else $error("Pointer 0 write did not activate it");
	AST_RSV_ZERO: assert property (
		rd_done && (idx == IDX_CTL) |-> (prdata[31:5] == 27'h0))
		else $error("Reserved control bits read nonzero");
	AST_WORD_READ: assert property (
		rd_done && (idx == IDX_WORD) |-> prdata == {16'h0, general_word})
		else $error("General word read wrong");
	AST_LOW_WRITE: assert property (
		wr_go && (idx == IDX_LOW) |=>
		general_word == {$past(general_word[15:8]), $past(pwdata[7:0])})
		else $error("Low byte write wrong or disturbed high byte");
	AST_HIGH_WRITE: assert property (
		wr_go && (idx == IDX_HIGH) |=>
		general_word == {$past(pwdata[7:0]), $past(general_word[7:0])})
		else $error("High byte write wrong");
	AST_HIGH_READ: assert property (
		rd_done && (idx == IDX_HIGH) |-> prdata == {24'h0, general_word[15:8]})
		else $error("High byte read wrong");
	AST_SWAP_READ: assert property (
		rd_done && (idx == IDX_SWAP) |->
		prdata[15:0] == {general_word[7:0], general_word[15:8]})
		else $error("Swap location did not return exchanged bytes");
	AST_SWAP_RO: assert property (
		wr_go && (idx == IDX_SWAP) |=> $stable(general_word))
		else $error("Write to swap location changed the word");
	AST_SWAP_ERR: assert property (
		access && !pready_ff && pwrite && (idx == IDX_SWAP) |=> pslverr)
		else $error("Write to swap location not refused");
	AST_LOW_READ: assert property (
		rd_done && (idx == IDX_LOW) |-> prdata == {24'h0, general_word[7:0]})
		else $error("Low byte read wrong");
	AST_ACTIVE_DECODE: assert property (
		source_pointer_select == 2'h3 |-> active_ptr == ptc_pkg::PTC_PTR_FRAME)
		else $error("Reserved select code not mapped to frame pointer");
	AST_PREADY_PULSE: assert property (
		pready |=> !pready)
		else $error("Ready stood longer than one cycle");

	COV_CTL_WRITE: cover property (ctl_wr ##1 src_ptr_active);
	COV_WRITE_THROUGH: cover property (wt_hit && !ctl_wr);
	COV_SWAP_READ: cover property (rd_done && (idx == IDX_SWAP));
	COV_DP0_ACT: cover property (core_wr_dp0 && !src_ptr_active && (sel_ptr == ptc_pkg::PTC_PTR_DP0));
endmodule

// ==== ptc_core_model.sv ====
// Core model: pointer write and data memory write events
`timescale 1ns/10ps
module ptc_core_model (
	// Clock
	input wire logic mclk,
	// Events to the block
	output logic wr_dp0,
	output logic wr_dp1,
	output logic wr_base,
	output logic wr_offs,
	output logic mem_wr,
	output ptc_pkg::ptc_ptr_t mem_wr_ptr
);
	initial begin
		{wr_dp0, wr_dp1, wr_base, wr_offs, mem_wr} = 5'h00;
		mem_wr_ptr = ptc_pkg::PTC_PTR_DP0;
	end
	// One-cycle pulse; k picks the event, p the pointer of a memory write
	task automatic ev(input int k, input int p);
		@(posedge mclk);
		wr_dp0 <= (k == 0);
		wr_dp1 <= (k == 1);
		wr_base <= (k == 2);
		wr_offs <= (k == 3);
		mem_wr <= (k == 4);
		mem_wr_ptr <= ptc_pkg::ptc_ptr_t'(p[1:0]);
		@(posedge mclk);
		{wr_dp0, wr_dp1, wr_base, wr_offs, mem_wr} <= 5'h00;
	endtask
endmodule

// ==== tb.sv ====
// Self-checking bench for the pointer control and general word block
`timescale 1ns/10ps
module tb;
	localparam int IX_CTL = 4, IX_GW = 5, IX_LO = 6, IX_SW = 8, IX_HI = 9;
	logic mclk, resetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic c0, c1, cb, co, cm, wt, act, awm, wm0, wm1, wmf;
	logic [1:0] sel;
	logic [15:0] gw;
	ptc_pkg::ptc_ptr_t cp, aptr;
	int err_total = 0, n_checks = 0;
	ptc_top i_ptc_top (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_wr_dp0(c0), .core_wr_dp1(c1), .core_wr_base(cb),
		.core_wr_offs(co), .core_mem_wr(cm), .core_mem_wr_ptr(cp), .write_through_en(wt),
		.source_pointer_select(sel), .src_ptr_active(act), .active_ptr(aptr),
		.active_word_mode(awm), .ptr0_word_mode(wm0), .ptr1_word_mode(wm1),
		.frame_ptr_word_mode(wmf), .general_word(gw));
	ptc_core_model i_ptc_core_model (.mclk(mclk), .wr_dp0(c0), .wr_dp1(c1), .wr_base(cb),
		.wr_offs(co), .mem_wr(cm), .mem_wr_ptr(cp));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Request held until pready is seen high at a rising edge
	task automatic rw(input logic w, input int ix, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= 12'(ix * 4);
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge mclk);
	endtask
	task automatic rdc(input int ix, input logic [31:0] e);
		rw(1'b0, ix, 32'h0);
		chk(rd, e);
	endtask
	task automatic ev(input int k, input int p);
		i_ptc_core_model.ev(k, p);
		@(negedge mclk);
	endtask
	initial begin
		repeat (5000) @(posedge mclk);
		err_total++;
		end_sim;
	end
	initial begin
		{resetn, psel, penable, pwrite, wt} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		rdc(IX_CTL, 32'h1C);
		chk(act, 1'b0);
		rdc(IX_GW, 32'h0);
		rdc(IX_LO, 32'h0);
		ev(1, 0);
		chk(act, 1'b0);
		ev(0, 0);
		chk(act, 1'b1);
		rw(1'b1, IX_CTL, 32'hFFFF_FFE3);
		rdc(IX_CTL, 32'h3);
		for (int i = 0; i < 8; i++) begin
			// Select pointer 1 so its mode shows on the active output
			rw(1'b1, IX_CTL, 32'((i << 2) | 1));
			chk({wmf, wm1, wm0}, 32'(i));
			chk(awm, 32'((i >> 1) & 1));
		end
		for (int s = 0; s < 4; s++) begin
			rw(1'b1, IX_CTL, 32'(s | 16'h1C));
			chk(sel, 32'(s));
			chk(aptr, 32'((s == 3) ? 2 : s));
		end
		ev(2, 0);
		ev(3, 0);
		ev(4, 1);
		chk(sel, 32'h3);
		@(posedge mclk);
		wt <= 1'b1;
		ev(4, 1);
		chk(sel, 32'h1);
		chk(aptr, 32'h1);
		ev(4, 2);
		chk(sel, 32'h2);
		rw(1'b1, IX_GW, 32'h1234);
		chk(gw, 32'h1234);
		rdc(IX_LO, 32'h34);
		rdc(IX_HI, 32'h12);
		rdc(IX_SW, 32'h3412);
		rw(1'b1, IX_LO, 32'hAB);
		rdc(IX_GW, 32'h12AB);
		rw(1'b1, IX_HI, 32'hCD);
		rdc(IX_GW, 32'hCDAB);
		rw(1'b1, IX_SW, 32'h5555);
		chk(err, 1'b1);
		rdc(IX_GW, 32'hCDAB);
		rw(1'b0, 3, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		end_sim;
	end
endmodule
